// [verilog/serial_channel.sv]
// Clock-synchronous serial channel with its AHB-Lite register file
`timescale 1ns/10ps
`include "serial_channel_regs.svh"

// Operation
// - Transmit and receive run independently on one shift clock, each double buffered.
// - Output bits change on falling serial clock edges, valid at rising edges.
// - Characters go LSB first; the data line holds the MSB afterwards.
// - Every character is exactly eight data bits, no parity or extra bit.
// - Shift clock is internal or external, chosen by mode and clock select bits.
// - Internal clock drives eight pulses per character; pin idles high.
// - Internal-clock receive keeps clocking until rx_enable clears or a receive error flag sets.
// - Clearing tx_enable sets tx_empty_flag and reinitialises the shift register.
// - Clearing rx_enable keeps the receive flags and receive buffer.
// - Clearing tx_empty_flag loads the shift register, sets flag, raises request.
// - At bit 7, chain the next character or set tx_done_flag.
// - Serial clock pin stays high after transmission ends while rx_enable is clear.
// - A finished character goes to the receive buffer and sets rx_full_flag.
// - A character finishing while rx_full_flag is set sets overrun_flag.
// - Any receive error flag halts transfers and blocks rx_full_flag.
// - Receive-full and receive-fault requests follow rx_irq_en.
// - Leftover parity or framing flags block transfers until cleared.
// - DMA writes to the transmit buffer or reads of receive buffer clear flags.
// - External clock edges on the clock pin time shifting and sampling.
module serial_channel (
  input wire logic clk,
  input wire logic srst,
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic dma_access,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic sck_in,
  output logic sck_out,
  output logic sck_oe,
  input wire logic rxd_in,
  output logic txd_out,
  output logic txd_oe,
  output logic tx_empty_irq,
  output logic rx_full_irq,
  output logic tx_done_irq,
  output logic rx_fault_irq
);
  shift_clock_if sc ();
  serial_channel_pkg::eng_state_type state_ff, nxt_state;
  serial_channel_pkg::char_type tx_buffer_reg_ff, rx_buffer_reg_ff, rx_char;
  logic [7:0] mode_ff, bit_rate_reg_ff, ctrl_ff, addr_ff;
  logic tx_empty_flag_ff, rx_full_flag_ff, overrun_flag_ff;
  logic framing_fault_flag_ff, parity_error_flag_ff, tx_done_flag_ff;
  logic [4:0] seen_ff;
  logic wr_pend_ff, rd_pend_ff, dma_ff, hreadyout_ff, hresp_ff;
  logic [31:0] hrdata_ff, rd_mux;
  logic rxd_sync1_ff, rxd_sync2_ff, sck_oe_ff, txd_oe_ff;
  logic tx_busy_ff, chain_ff;
  logic [3:0] irq_ff;
  logic addr_take, wr_ctrl, wr_stat, wr_txbuf, rd_stat, rd_rxbuf;
  logic tx_enable, rx_enable, tx_en_fall, sync_mode, ext_clk, rx_err;
  logic start_tx, load, bit7_fall, done, txd;
  // AHB-Lite access decode
  assign addr_take = hsel && htrans[1] && hready;
  assign wr_ctrl = wr_pend_ff && (addr_ff == `CTRL_REG_OFS);
  assign wr_stat = wr_pend_ff && (addr_ff == `STAT_REG_OFS);
  assign wr_txbuf = wr_pend_ff && (addr_ff == `TXBUF_REG_OFS);
  assign rd_stat = rd_pend_ff && (addr_ff == `STAT_REG_OFS);
  assign rd_rxbuf = rd_pend_ff && (addr_ff == `RXBUF_REG_OFS);

  assign tx_enable = ctrl_ff[`CTRL_TXEN_BIT];
  assign rx_enable = ctrl_ff[`CTRL_RXEN_BIT];
  assign tx_en_fall = wr_ctrl && tx_enable && !hwdata[`CTRL_TXEN_BIT];
  assign sync_mode = mode_ff[`MODE_SYNC_BIT];
  assign ext_clk = ctrl_ff[`CTRL_CKE_HI_BIT];
  assign rx_err = overrun_flag_ff || framing_fault_flag_ff
                  || parity_error_flag_ff;

  always_ff @(posedge clk) begin
    if (srst) begin
      wr_pend_ff <= 1'b0;
      rd_pend_ff <= 1'b0;
      dma_ff <= 1'b0;
      addr_ff <= 8'h00;
    end else begin
      wr_pend_ff <= addr_take && hwrite;
      rd_pend_ff <= addr_take && !hwrite;
      if (addr_take) begin
        addr_ff <= {haddr[7:2], 2'b00};
        dma_ff <= dma_access;
      end
    end
  end

  // Reads take one wait state so a preceding write is always visible
  always_ff @(posedge clk) begin
    hreadyout_ff <= srst || !(addr_take && !hwrite);
    hresp_ff <= 1'b0;
  end

  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (addr_ff)
      `MODE_REG_OFS: rd_mux[7:0] = mode_ff;
      `RATE_REG_OFS: rd_mux[7:0] = bit_rate_reg_ff;
      `CTRL_REG_OFS: rd_mux[7:0] = ctrl_ff;
      `TXBUF_REG_OFS: rd_mux[7:0] = tx_buffer_reg_ff;
      `STAT_REG_OFS: begin
        rd_mux[`STAT_TX_EMPTY_FLAG_BIT] = tx_empty_flag_ff;
        rd_mux[`STAT_RX_FULL_FLAG_BIT] = rx_full_flag_ff;
        rd_mux[`STAT_OVERRUN_FLAG_BIT] = overrun_flag_ff;
        rd_mux[`STAT_FER_BIT] = framing_fault_flag_ff;
        rd_mux[`STAT_PER_BIT] = parity_error_flag_ff;
        rd_mux[`STAT_TX_DONE_FLAG_BIT] = tx_done_flag_ff;
      end
      `RXBUF_REG_OFS: rd_mux[7:0] = rx_buffer_reg_ff;
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      hrdata_ff <= 32'h0000_0000;
    end else if (rd_pend_ff) begin
      hrdata_ff <= rd_mux;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      mode_ff <= `MODE_RESET;
      bit_rate_reg_ff <= `RATE_RESET;
      ctrl_ff <= `CTRL_RESET;
    end else if (wr_pend_ff) begin
      if (addr_ff == `MODE_REG_OFS) begin
        mode_ff <= hwdata[7:0];
      end
      if (addr_ff == `RATE_REG_OFS) begin
        bit_rate_reg_ff <= hwdata[7:0];
      end
      if (addr_ff == `CTRL_REG_OFS) begin
        ctrl_ff <= hwdata[7:0];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      tx_buffer_reg_ff <= `TXBUF_RESET;
    end else if (wr_txbuf) begin
      tx_buffer_reg_ff <= hwdata[7:0];
    end
  end

  // Flags seen as 1 by a status read may then be cleared by a write of 0
  always_ff @(posedge clk) begin
    if (srst) begin
      seen_ff <= 5'h00;
    end else if (rd_stat) begin
      seen_ff <= {tx_empty_flag_ff, rx_full_flag_ff, overrun_flag_ff,
                  framing_fault_flag_ff, parity_error_flag_ff};
    end else if (wr_stat) begin
      seen_ff <= 5'h00;
    end
  end

  // Serial engine
  assign start_tx = tx_enable && !tx_empty_flag_ff && !rx_err && sync_mode;
  assign load = (state_ff == serial_channel_pkg::ENG_IDLE || ext_clk)
                  && !tx_busy_ff && start_tx
                || done && (chain_ff || !tx_busy_ff && start_tx);

  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      serial_channel_pkg::ENG_IDLE: begin
        if (!rx_err && sync_mode && (ext_clk ? (tx_enable || rx_enable)
            : (start_tx || rx_enable))) begin
          nxt_state = serial_channel_pkg::ENG_RUN;
        end
      end
      serial_channel_pkg::ENG_RUN: begin
        if (rx_err || !sync_mode || !(tx_enable || rx_enable)) begin
          nxt_state = serial_channel_pkg::ENG_IDLE;
        end else if (ext_clk) begin
          nxt_state = serial_channel_pkg::ENG_RUN;
        end else if (done && !chain_ff && !rx_enable) begin
          nxt_state = serial_channel_pkg::ENG_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      state_ff <= serial_channel_pkg::ENG_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end
  // Next character is chained when the buffer is full at bit 7
  always_ff @(posedge clk) begin
    if (srst || tx_en_fall) begin
      chain_ff <= 1'b0;
    end else if (bit7_fall) begin
      chain_ff <= tx_busy_ff && !tx_empty_flag_ff && tx_enable;
    end else if (done) begin
      chain_ff <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (srst || tx_en_fall) begin
      tx_busy_ff <= 1'b0;
    end else if (load) begin
      tx_busy_ff <= 1'b1;
    end else if (done) begin
      tx_busy_ff <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      tx_empty_flag_ff <= 1'b1;
    end else if (load || !tx_enable || tx_en_fall) begin
      tx_empty_flag_ff <= 1'b1;
    end else if (wr_txbuf && dma_ff) begin
      tx_empty_flag_ff <= 1'b0;
    end else if (wr_stat && seen_ff[4] && !hwdata[`STAT_TX_EMPTY_FLAG_BIT]) begin
      tx_empty_flag_ff <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      tx_done_flag_ff <= 1'b1;
    end else if (bit7_fall && tx_busy_ff && tx_empty_flag_ff) begin
      tx_done_flag_ff <= 1'b1;
    end else if (load) begin
      tx_done_flag_ff <= 1'b0;
    end
  end

  // Receive flags keep their values when rx_enable clears
  always_ff @(posedge clk) begin
    if (srst) begin
      rx_full_flag_ff <= 1'b0;
    end else if (done && rx_enable && !rx_full_flag_ff && !rx_err) begin
      rx_full_flag_ff <= 1'b1;
    end else if (rd_rxbuf && dma_ff) begin
      rx_full_flag_ff <= 1'b0;
    end else if (wr_stat && seen_ff[3] && !hwdata[`STAT_RX_FULL_FLAG_BIT]) begin
      rx_full_flag_ff <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      rx_buffer_reg_ff <= `RXBUF_RESET;
    end else if (done && rx_enable && !rx_full_flag_ff && !rx_err) begin
      rx_buffer_reg_ff <= rx_char;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      overrun_flag_ff <= 1'b0;
    end else if (done && rx_enable && rx_full_flag_ff) begin
      overrun_flag_ff <= 1'b1;
    end else if (wr_stat && seen_ff[2] && !hwdata[`STAT_OVERRUN_FLAG_BIT]) begin
      overrun_flag_ff <= 1'b0;
    end
  end

  // Framing and parity are never raised in this mode, only cleared
  always_ff @(posedge clk) begin
    if (srst) begin
      framing_fault_flag_ff <= 1'b0;
      parity_error_flag_ff <= 1'b0;
    end else if (wr_stat) begin
      if (seen_ff[1] && !hwdata[`STAT_FER_BIT]) begin
        framing_fault_flag_ff <= 1'b0;
      end
      if (seen_ff[0] && !hwdata[`STAT_PER_BIT]) begin
        parity_error_flag_ff <= 1'b0;
      end
    end
  end

  // Interrupt request levels
  always_ff @(posedge clk) begin
    if (srst) begin
      irq_ff <= 4'h0;
    end else begin
      irq_ff[0] <= ctrl_ff[`CTRL_TIE_BIT] && tx_empty_flag_ff;
      irq_ff[1] <= ctrl_ff[`CTRL_RIE_BIT] && rx_full_flag_ff;
      irq_ff[2] <= ctrl_ff[`CTRL_TX_DONE_IRQ_EN_BIT] && tx_done_flag_ff;
      irq_ff[3] <= ctrl_ff[`CTRL_RIE_BIT] && rx_err;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      sck_oe_ff <= 1'b0;
      txd_oe_ff <= 1'b0;
    end else begin
      sck_oe_ff <= sync_mode && !ext_clk && (tx_enable || rx_enable);
      txd_oe_ff <= tx_enable;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      rxd_sync1_ff <= 1'b1;
      rxd_sync2_ff <= 1'b1;
    end else begin
      rxd_sync1_ff <= rxd_in;
      rxd_sync2_ff <= rxd_sync1_ff;
    end
  end
  assign sc.run = (state_ff == serial_channel_pkg::ENG_RUN);
  assign sc.ext_sel = ext_clk;
  assign sc.rate = bit_rate_reg_ff;

  shift_clock_gen u_clk (
    .clk(clk),
    .srst(srst),
    .sck_in(sck_in),
    .sc(sc.gen)
  );

  char_shifter u_shift (
    .clk(clk),
    .srst(srst),
    .sc(sc.mon),
    .tx_init(tx_en_fall),
    .load(load),
    .load_data(tx_buffer_reg_ff),
    .tx_busy(tx_busy_ff),
    .rxd(rxd_sync2_ff),
    .txd(txd),
    .bit7_fall(bit7_fall),
    .done(done),
    .rx_char(rx_char)
  );

  assign hrdata = hrdata_ff;
  assign hreadyout = hreadyout_ff;
  assign hresp = hresp_ff;
  assign sck_out = sc.level;
  assign sck_oe = sck_oe_ff;
  assign txd_out = txd;
  assign txd_oe = txd_oe_ff;
  assign tx_empty_irq = irq_ff[0];
  assign rx_full_irq = irq_ff[1];
  assign tx_done_irq = irq_ff[2];
  assign rx_fault_irq = irq_ff[3];
endmodule

// [common/serial_channel_regs.svh]
// Register offsets, field positions and reset values of the serial channel
`ifndef SERIAL_CHANNEL_REGS_SVH
`define SERIAL_CHANNEL_REGS_SVH

`define MODE_REG_OFS 8'h00
`define RATE_REG_OFS 8'h04
`define CTRL_REG_OFS 8'h08
`define TXBUF_REG_OFS 8'h0c
`define STAT_REG_OFS 8'h10
`define RXBUF_REG_OFS 8'h14

`define MODE_SYNC_BIT 0

`define CTRL_CKE_LO_BIT 0
`define CTRL_CKE_HI_BIT 1
`define CTRL_TX_DONE_IRQ_EN_BIT 2
`define CTRL_MULTIPROC_IRQ_EN_BIT 3
`define CTRL_RXEN_BIT 4
`define CTRL_TXEN_BIT 5
`define CTRL_RIE_BIT 6
`define CTRL_TIE_BIT 7

`define STAT_TX_DONE_FLAG_BIT 2
`define STAT_PER_BIT 3
`define STAT_FER_BIT 4
`define STAT_OVERRUN_FLAG_BIT 5
`define STAT_RX_FULL_FLAG_BIT 6
`define STAT_TX_EMPTY_FLAG_BIT 7

`define MODE_RESET 8'h00
`define RATE_RESET 8'hff
`define CTRL_RESET 8'h00
`define TXBUF_RESET 8'hff
`define RXBUF_RESET 8'h00

`endif

// [common/serial_channel_pkg.sv]
// Types shared by the serial channel modules
package serial_channel_pkg;
  typedef enum logic [0:0] {
    ENG_IDLE = 1'b0,
    ENG_RUN = 1'b1
  } eng_state_type;
  typedef logic [7:0] char_type;
endpackage

// [common/shift_clock_if.sv]
// Shift clock control and edge events between the channel modules
`timescale 1ns/10ps
interface shift_clock_if;
  logic run;
  logic ext_sel;
  logic [7:0] rate;
  logic rise;
  logic fall;
  logic level;
  modport gen (input run, input ext_sel, input rate,
               output rise, output fall, output level);
  modport ctl (output run, output ext_sel, output rate,
               input rise, input fall, input level);
  modport mon (input rise, input fall);
endinterface

// [verilog/shift_clock_gen.sv]
// Baud rate divider, internal shift clock and external clock edge detect
`timescale 1ns/10ps
module shift_clock_gen (
  input wire logic clk,
  input wire logic srst,
  input wire logic sck_in,
  shift_clock_if.gen sc
);
  logic [7:0] div_ff;
  logic level_ff;
  logic sync1_ff;
  logic sync2_ff;
  logic sync3_ff;
  logic tick;

  assign tick = sc.run && !sc.ext_sel && (div_ff == sc.rate);

  // Divider: half a shift clock period is rate+1 system clocks
  always_ff @(posedge clk) begin
    if (srst || !sc.run || sc.ext_sel) begin
      div_ff <= 8'h00;
    end else if (tick) begin
      div_ff <= 8'h00;
    end else begin
      div_ff <= div_ff + 8'h01;
    end
  end

  // Internal clock idles high
  always_ff @(posedge clk) begin
    if (srst || !sc.run || sc.ext_sel) begin
      level_ff <= 1'b1;
    end else if (tick) begin
      level_ff <= ~level_ff;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      sync1_ff <= 1'b1;
      sync2_ff <= 1'b1;
      sync3_ff <= 1'b1;
    end else begin
      sync1_ff <= sck_in;
      sync2_ff <= sync1_ff;
      sync3_ff <= sync2_ff;
    end
  end

  assign sc.level = level_ff;
  assign sc.fall = sc.ext_sel ? (sc.run && sync3_ff && !sync2_ff)
                              : (tick && level_ff);
  assign sc.rise = sc.ext_sel ? (sc.run && !sync3_ff && sync2_ff)
                              : (tick && !level_ff);
endmodule

// [verilog/char_shifter.sv]
// Transmit and receive shift registers with the shared bit counter
`timescale 1ns/10ps
module char_shifter (
  input wire logic clk,
  input wire logic srst,
  shift_clock_if.mon sc,
  input wire logic tx_init,
  input wire logic load,
  input wire serial_channel_pkg::char_type load_data,
  input wire logic tx_busy,
  input wire logic rxd,
  output logic txd,
  output logic bit7_fall,
  output logic done,
  output serial_channel_pkg::char_type rx_char
);
  serial_channel_pkg::char_type tsr_ff;
  serial_channel_pkg::char_type rsr_ff;
  logic [2:0] cnt_ff;
  logic txd_ff;

  assign bit7_fall = sc.fall && (cnt_ff == 3'h7);
  assign done = sc.rise && (cnt_ff == 3'h7);
  assign txd = txd_ff;
  // Bit 7 lands on the edge that ends the character, so take it directly
  assign rx_char = {rxd, rsr_ff[6:0]};

  always_ff @(posedge clk) begin
    if (srst || tx_init) begin
      tsr_ff <= 8'hff;
    end else if (load) begin
      tsr_ff <= load_data;
    end
  end

  // New bit on each falling edge, LSB first; line holds after MSB
  always_ff @(posedge clk) begin
    if (srst) begin
      txd_ff <= 1'b1;
    end else if (sc.fall && tx_busy) begin
      txd_ff <= tsr_ff[cnt_ff];
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      rsr_ff <= 8'h00;
    end else if (sc.rise) begin
      rsr_ff[cnt_ff] <= rxd;
    end
  end

  // Eight bits per character
  always_ff @(posedge clk) begin
    if (srst || tx_init) begin
      cnt_ff <= 3'h0;
    end else if (sc.rise) begin
      cnt_ff <= cnt_ff + 3'h1;
    end
  end
endmodule

// [dv/serial_channel_properties.sv]
// Concurrent checks on the serial channel top-level ports
`timescale 1ns/10ps
module serial_channel_properties (
  input wire logic clk,
  input wire logic srst,
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic sck_out,
  input wire logic sck_oe,
  input wire logic txd_out,
  input wire logic txd_oe,
  input wire logic tx_done_irq,
  input wire logic rx_fault_irq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  reset_state_a: assert property (disable iff (1'b0)
    srst |=> sck_out && txd_out && !sck_oe && !txd_oe && hreadyout)
    else $error("outputs not at reset state");
  read_wait_a: assert property (
    hsel && htrans[1] && hready && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read data phase not one wait state");
  write_nowait_a: assert property (
    hsel && htrans[1] && hready && hwrite |=> hreadyout)
    else $error("write data phase stalled");
  okay_resp_a: assert property (!hresp)
    else $error("response not okay");
  clock_drive_a: assert property ($fell(sck_out) |-> sck_oe)
    else $error("serial clock fell while not driven");
  txd_fall_a: assert property (
    $changed(txd_out) && sck_oe |-> !sck_out)
    else $error("data changed while serial clock high");
  fault_halt_a: assert property (
    rx_fault_irq && $past(rx_fault_irq) |-> !$fell(sck_out))
    else $error("clock ran during receive error");
  done_idle_a: assert property (
    $rose(tx_done_irq) |-> ##[0:600] sck_out)
    else $error("serial clock not high after transmit end");
endmodule

bind serial_channel serial_channel_properties i_serial_channel_properties (
  .clk, .srst, .hsel, .htrans, .hwrite, .hready, .hreadyout, .hresp,
  .sck_out, .sck_oe, .txd_out, .txd_oe, .tx_done_irq, .rx_fault_irq);

// [dv/sync_peer_model.sv]
// Behavioural external synchronous serial device on the shared clock
`timescale 1ns/10ps
module sync_peer_model (
  input wire logic sck,
  input wire logic txd,
  input wire logic send_en,
  output logic rxd,
  output logic [15:0] got,
  output int rises
);
  logic [7:0] pat;
  logic [2:0] idx;
  initial begin
    rxd = 1'b1;
    got = 16'h0000;
    rises = 0;
    pat = 8'ha5;
    idx = 3'h0;
  end
  // Capture device data on rising clock edges, LSB first
  always @(posedge sck) begin
    got <= {txd, got[15:1]};
    rises <= rises + 1;
  end
  // Drive a counting byte on falling edges; idle line keeps toggling
  always @(negedge sck) begin
    if (send_en) begin
      rxd <= pat[idx];
      idx <= idx + 3'h1;
      if (idx == 3'h7) begin
        pat <= pat + 8'h01;
      end
    end else begin
      rxd <= ~rxd;
    end
  end
endmodule

// [dv/serial_channel_tb_top.sv]
// Self-checking testbench of the serial channel
`timescale 1ns/10ps
`include "serial_channel_regs.svh"
`define CHK(a, e) begin \
  n_compared++; \
  if ((a) !== (e)) begin \
    bad_count++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (e)); \
  end \
end
module serial_channel_tb_top;
  logic clk, srst, hsel, hwrite, hready, dma_access, sck_out, sck_oe;
  logic txd_out, txd_oe, hreadyout, hresp, send_en, rxd, ext_sck;
  logic tx_empty_irq, rx_full_irq, tx_done_irq, rx_fault_irq;
  logic [7:0] haddr;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] hwdata, hrdata, rdat;
  logic [15:0] got;
  int rises, rises0, bad_count, n_compared;
  wire sck_pin, txd_pin;
  // Data pin pulled up; the far side drives the clock pin when released
  assign sck_pin = sck_oe ? sck_out : ext_sck;
  assign txd_pin = txd_oe ? txd_out : 1'b1;
  assign hready = hreadyout;
  serial_channel i_serial_channel (.clk(clk), .srst(srst), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hready), .dma_access(dma_access),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .sck_in(sck_pin), .sck_out(sck_out), .sck_oe(sck_oe), .rxd_in(rxd),
    .txd_out(txd_out), .txd_oe(txd_oe), .tx_empty_irq(tx_empty_irq),
    .rx_full_irq(rx_full_irq), .tx_done_irq(tx_done_irq),
    .rx_fault_irq(rx_fault_irq));
  sync_peer_model i_sync_peer_model (.sck(sck_pin), .txd(txd_pin),
    .send_en(send_en), .rxd(rxd), .got(got), .rises(rises));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task automatic tally_and_finish();
    $display("compared=%0d mismatches=%0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic bus(input logic wr, input logic [7:0] a,
                     input logic [31:0] wd, input logic dma);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= wr;
    dma_access <= dma;
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    dma_access <= 1'b0;
    hwdata <= wd;
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    rdat = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d, 1'b0);
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] m,
                       input logic [31:0] e);
    bus(1'b0, a, 32'h0, 1'b0);
    `CHK(rdat & m, e)
  endtask
  // Flags clear by a read followed by a write of zero
  task automatic clr_flags(input logic [31:0] d);
    bus(1'b0, `STAT_REG_OFS, 32'h0, 1'b0);
    wr(`STAT_REG_OFS, d);
  endtask
  task automatic t_reset();
    rdchk(`MODE_REG_OFS, 32'hffffffff, 32'h00000000);
    rdchk(`RATE_REG_OFS, 32'hffffffff, 32'h000000ff);
    rdchk(`CTRL_REG_OFS, 32'hffffffff, 32'h00000000);
    rdchk(`STAT_REG_OFS, 32'h000000fc, 32'h00000084);
    rdchk(`RXBUF_REG_OFS, 32'hffffffff, 32'h00000000);
    wr(8'h18, 32'h000000ff);
    rdchk(8'h18, 32'hffffffff, 32'h00000000);
  endtask
  task automatic t_tx();
    wr(`CTRL_REG_OFS, 32'h0);
    wr(`MODE_REG_OFS, 32'h1);
    wr(`RATE_REG_OFS, 32'h3);
    wait_cyc(16);
    wr(`CTRL_REG_OFS, 32'ha4);
    rises0 = rises;
    wr(`TXBUF_REG_OFS, 32'ha5);
    clr_flags(32'h0);
    wait_cyc(4);
    `CHK(tx_empty_irq, 1'b1)
    `CHK(tx_done_irq, 1'b0)
    wr(`TXBUF_REG_OFS, 32'h3c);
    clr_flags(32'h0);
    while (tx_done_irq !== 1'b1) @(posedge clk);
    wait_cyc(20);
    `CHK(got, 16'h3ca5)
    `CHK(rises - rises0, 16)
    `CHK(txd_pin, 1'b0)
    `CHK(sck_pin, 1'b1)
  endtask
  task automatic t_dma();
    rises0 = rises;
    bus(1'b1, `TXBUF_REG_OFS, 32'hc3, 1'b1);
    while (tx_done_irq !== 1'b0) @(posedge clk);
    while (tx_done_irq !== 1'b1) @(posedge clk);
    wait_cyc(20);
    `CHK(got[15:8], 8'hc3)
    `CHK(rises - rises0, 8)
    `CHK(txd_pin, 1'b1)
    wr(`CTRL_REG_OFS, 32'h0);
    rdchk(`STAT_REG_OFS, 32'h80, 32'h80);
  endtask
  task automatic t_rx();
    send_en <= 1'b1;
    wait_cyc(2);
    wr(`CTRL_REG_OFS, 32'h50);
    while (rx_full_irq !== 1'b1) @(posedge clk);
    bus(1'b0, `RXBUF_REG_OFS, 32'h0, 1'b1);
    `CHK(rdat[7:0], 8'ha5)
    rdchk(`STAT_REG_OFS, 32'h40, 32'h0);
    while (rx_fault_irq !== 1'b1) @(posedge clk);
    `CHK(rx_full_irq, 1'b1)
    rdchk(`STAT_REG_OFS, 32'h60, 32'h60);
    rdchk(`RXBUF_REG_OFS, 32'hff, 32'ha6);
    rises0 = rises;
    wait_cyc(40);
    `CHK(rises, rises0)
    wr(`STAT_REG_OFS, 32'hff);
    rdchk(`STAT_REG_OFS, 32'h20, 32'h20);
    wr(`CTRL_REG_OFS, 32'h0);
    rdchk(`STAT_REG_OFS, 32'h60, 32'h60);
    rdchk(`RXBUF_REG_OFS, 32'hff, 32'ha6);
    clr_flags(32'h80);
    rdchk(`STAT_REG_OFS, 32'h60, 32'h0);
  endtask
  // External clock: far side supplies eight slow pulses on the clock pin
  task automatic t_ext();
    wr(`CTRL_REG_OFS, 32'h02);
    wait_cyc(8);
    wr(`CTRL_REG_OFS, 32'h22);
    wr(`TXBUF_REG_OFS, 32'h96);
    clr_flags(32'h0);
    repeat (8) begin
      wait_cyc(8);
      ext_sck <= 1'b0;
      wait_cyc(8);
      ext_sck <= 1'b1;
    end
    wait_cyc(8);
    `CHK(got[15:8], 8'h96)
    `CHK(sck_oe, 1'b0)
    `CHK(sck_out, 1'b1)
    `CHK(txd_pin, 1'b1)
  endtask
  initial begin
    srst = 1'b1;
    hsel = 1'b0;
    haddr = 8'h00;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    dma_access = 1'b0;
    send_en = 1'b0;
    ext_sck = 1'b1;
    bad_count = 0;
    n_compared = 0;
    repeat (8) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    t_reset();
    t_tx();
    t_dma();
    t_rx();
    t_ext();
    tally_and_finish();
  end
  // Whole run needs well under two thousand cycles
  initial begin
    repeat (5000) @(posedge clk);
    bad_count++;
    tally_and_finish();
  end
endmodule
